// File: ocr_pkg.sv
package ocr_pkg;

  // Bus and clock
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam longint PCLK_HZ = 64'd50_000_000;

  // Output clock synthesis timebase, frequencies in kHz
  localparam int NUM_CLK = 7;
  localparam logic [31:0] PHASE_MOD_KHZ = 32'h0009_8968;
  localparam logic [31:0] FREQ1_RST = 32'h0000_61a8;
  localparam logic [31:0] FREQ2_RST = 32'h0000_f424;
  localparam logic [31:0] FREQ3_RST = 32'h0001_2fc0;
  localparam logic [31:0] FREQ4_RST = 32'h0001_e848;
  localparam logic [31:0] FREQ5_RST = 32'h0002_5f80;
  localparam logic [31:0] FREQ6_RST = 32'h0002_625a;
  localparam logic [31:0] FREQ7_RST = 32'h0004_c4b4;

  // Register byte offsets
  localparam logic [7:0] FREQ_BASE_OFS = 8'h00;
  localparam logic [7:0] MASTER_CONFIG_8_OFS = 8'h1c;
  localparam logic [7:0] OUTPUT_CONFIG_6_OFS = 8'h20;
  localparam logic [7:0] FRAME_SYNC_CONFIG_1_OFS = 8'h24;
  localparam logic [7:0] GPIO_CTRL_OFS = 8'h28;
  localparam logic [7:0] STATUS_OFS = 8'h2c;

  // Signal format codes
  localparam logic [1:0] FMT_LVDS = 2'h0;
  localparam logic [1:0] FMT_LVPECL = 2'h1;
  localparam logic [1:0] FMT_OFF = 2'h2;

  // Field positions
  localparam int MC8_OUT4_POS = 0;
  localparam int MC8_OUT5_POS = 2;
  localparam int MC8_OUT6_POS = 4;
  localparam int MC8_OUT7_POS = 6;
  localparam int GPIO_OUT_POS = 4;
  localparam int ST_CLK_POS = 8;
  localparam int ST_COPY_POS = 16;
  localparam int ST_SYNC_POS = 24;
  localparam logic [7:0] MASTER_CONFIG_8_RST = 8'h00;
  localparam logic [4:0] OUTPUT_CONFIG_6_RST = 5'h00;

  // Frame sync timing
  localparam longint FAST_FRAME_HZ = 64'd8_000;
  localparam longint SLOW_FRAME_HZ = 64'd2_000;
  localparam int FAST_FRAME_CYCLES = int'(PCLK_HZ / FAST_FRAME_HZ);
  localparam int SLOW_PER_FAST = int'(FAST_FRAME_HZ / SLOW_FRAME_HZ);
  localparam longint SYNC_PULSE_NS = 64'd160;
  localparam longint PCLK_PERIOD_NS = 64'd1_000_000_000 / PCLK_HZ;
  localparam int SYNC_PULSE_CYCLES = int'((SYNC_PULSE_NS + PCLK_PERIOD_NS - 1) / PCLK_PERIOD_NS);

  typedef struct packed {
    logic pulse;
    logic invert;
  } ocr_sync_mode_type;

  typedef struct packed {
    ocr_sync_mode_type slow;
    ocr_sync_mode_type fast;
  } ocr_sync_cfg_type;

  typedef struct packed {
    logic true_lvl;
    logic comp_lvl;
  } ocr_diff_type;

endpackage

// File: ocr_output_routing.sv
// The register addresses and the APB register port are this design's own decisions.
`timescale 1ns/10ps
// Notes on behaviour
// - Clock 1 resets to 25 MHz, programmable
// - Clock 2 resets to 62.5 MHz, programmable
// - Clock 3 resets to 77.76 MHz, programmable
// - Clock 4 resets to 125 MHz, programmable
// - Clock 5 resets to 155.52 MHz, programmable
// - Pair 6 resets 156.25 MHz LVDS, format field
// - Pair 7 resets 312.5 MHz LVDS, format field
// - Pair 4 mirrors clock 4, format field
// - Pair 5 mirrors clock 5, format field
// - Shared pin 1: clock 1 copy or GPIO
// - Shared pin 2: clock 2 copy or GPIO
// - Shared pin 3: clock 3 copy or GPIO
// - Copy 4 off at reset, else clock 4
// - Copy 5 off at reset, else clock 5
// - 8 kHz output, default non-inverted square
// - 8 kHz invert and pulse mode bits
// - 2 kHz output, default non-inverted square
// - 2 kHz invert and pulse mode bits
module ocr_output_routing #(
  parameter int FAST_FRAME_CYCLES = ocr_pkg::FAST_FRAME_CYCLES,
  parameter logic [31:0] PHASE_MOD_KHZ = ocr_pkg::PHASE_MOD_KHZ
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ocr_pkg::ADDR_W-1:0] paddr,
  input wire logic [ocr_pkg::DATA_W-1:0] pwdata,
  output logic [ocr_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic output_clock_1,
  output logic output_clock_2,
  output logic output_clock_3,
  output logic output_clock_4,
  output logic output_clock_5,
  output logic diff_out4_true,
  output logic diff_out4_comp,
  output logic diff_out5_true,
  output logic diff_out5_comp,
  output logic diff_out6_true,
  output logic diff_out6_comp,
  output logic diff_out7_true,
  output logic diff_out7_comp,
  output logic [1:0] out4_signal_format,
  output logic [1:0] out5_signal_format,
  output logic [1:0] out6_signal_format,
  output logic [1:0] out7_signal_format,
  output logic [2:0] copy_pin_out,
  output logic [2:0] copy_pin_oe_n,
  input wire logic [2:0] copy_pin_in,
  output logic copy4_pin,
  output logic copy4_pin_oe_n,
  output logic copy5_pin,
  output logic copy5_pin_oe_n,
  output logic frame_sync_out,
  output logic multiframe_sync_out
);

  localparam logic [31:0] HALF_MOD = PHASE_MOD_KHZ >> 1;
  localparam logic [15:0] FAST_LAST = 16'(FAST_FRAME_CYCLES - 1);
  localparam logic [15:0] FAST_HALF = 16'(FAST_FRAME_CYCLES / 2);
  localparam logic [15:0] PULSE_CYC = 16'(ocr_pkg::SYNC_PULSE_CYCLES);
  localparam logic [1:0] SLOW_LAST = 2'(ocr_pkg::SLOW_PER_FAST - 1);
  localparam logic [1:0] SLOW_HALF = 2'(ocr_pkg::SLOW_PER_FAST / 2);

  localparam logic [31:0] FREQ_RST [ocr_pkg::NUM_CLK] = '{
    ocr_pkg::FREQ1_RST, ocr_pkg::FREQ2_RST, ocr_pkg::FREQ3_RST, ocr_pkg::FREQ4_RST,
    ocr_pkg::FREQ5_RST, ocr_pkg::FREQ6_RST, ocr_pkg::FREQ7_RST};

  // Sync output level from mode bits
  function automatic logic sync_level(input logic square, input logic pulse,
                                      input ocr_pkg::ocr_sync_mode_type mode);
    sync_level = (mode.pulse ? pulse : square) ^ mode.invert;
  endfunction

  // Register file
  logic [31:0] freq_reg [ocr_pkg::NUM_CLK];
  logic [7:0] master_config_8_reg;
  logic [4:0] output_config_6_reg;
  ocr_pkg::ocr_sync_cfg_type frame_sync_config_1_reg;
  logic [2:0] gpio_dir_reg;
  logic [2:0] gpio_out_reg;

  // Clock synthesis and routing state
  logic [31:0] acc_reg [ocr_pkg::NUM_CLK];
  logic [31:0] acc_next [ocr_pkg::NUM_CLK];
  logic [ocr_pkg::NUM_CLK-1:0] clk_next;
  logic [ocr_pkg::NUM_CLK-1:0] clk_reg;
  ocr_pkg::ocr_diff_type diff_reg [4];
  logic [4:0] copy_en_reg;
  logic [2:0] copy_pin_out_reg;
  logic [2:0] copy_pin_oe_n_reg;
  logic copy4_reg;
  logic copy4_oe_n_reg;
  logic copy5_reg;
  logic copy5_oe_n_reg;

  // Frame sync state
  logic [15:0] fast_cnt_reg;
  logic [1:0] slow_idx_reg;
  logic frame_sync_reg;
  logic multiframe_sync_reg;

  // Bus state
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic access;
  logic wr_en;
  logic [31:0] rd_next;
  logic hit;

  assign access = psel & penable & ~pready_reg;
  assign wr_en = psel & penable & pready_reg & pwrite & ~pslverr_reg;

  // Address decode and read mux
  always_comb begin
    rd_next = 32'h0000_0000;
    hit = 1'b1;
    if (paddr[1:0] != 2'h0) begin
      hit = 1'b0;
    end else if (paddr < ocr_pkg::MASTER_CONFIG_8_OFS) begin
      rd_next = freq_reg[paddr[4:2]];
    end else begin
      case (paddr)
        ocr_pkg::MASTER_CONFIG_8_OFS: rd_next[7:0] = master_config_8_reg;
        ocr_pkg::OUTPUT_CONFIG_6_OFS: rd_next[4:0] = output_config_6_reg;
        ocr_pkg::FRAME_SYNC_CONFIG_1_OFS: rd_next[3:0] = frame_sync_config_1_reg;
        ocr_pkg::GPIO_CTRL_OFS: begin
          rd_next[2:0] = gpio_dir_reg;
          rd_next[ocr_pkg::GPIO_OUT_POS +: 3] = gpio_out_reg;
        end
        ocr_pkg::STATUS_OFS: begin
          rd_next[2:0] = copy_pin_in;
          rd_next[ocr_pkg::ST_CLK_POS +: ocr_pkg::NUM_CLK] = clk_reg;
          rd_next[ocr_pkg::ST_COPY_POS +: 5] = copy_en_reg;
          rd_next[ocr_pkg::ST_SYNC_POS] = frame_sync_reg;
          rd_next[ocr_pkg::ST_SYNC_POS + 1] = multiframe_sync_reg;
        end
        default: hit = 1'b0;
      endcase
    end
  end

  // APB answer, one wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      pready_reg <= access;
      pslverr_reg <= access & ~hit;
      if (access) begin
        prdata_reg <= (pwrite | ~hit) ? 32'h0000_0000 : rd_next;
      end
    end
  end

  // Frequency registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < ocr_pkg::NUM_CLK; i++) begin
        freq_reg[i] <= FREQ_RST[i];
      end
    end else if (wr_en && paddr < ocr_pkg::MASTER_CONFIG_8_OFS) begin
      freq_reg[paddr[4:2]] <= (pwdata >= PHASE_MOD_KHZ) ? HALF_MOD : pwdata;
    end
  end

  // Configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      master_config_8_reg <= ocr_pkg::MASTER_CONFIG_8_RST;
      output_config_6_reg <= ocr_pkg::OUTPUT_CONFIG_6_RST;
      frame_sync_config_1_reg <= '0;
      gpio_dir_reg <= 3'h0;
      gpio_out_reg <= 3'h0;
    end else if (wr_en) begin
      case (paddr)
        ocr_pkg::MASTER_CONFIG_8_OFS: master_config_8_reg <= pwdata[7:0];
        ocr_pkg::OUTPUT_CONFIG_6_OFS: output_config_6_reg <= pwdata[4:0];
        ocr_pkg::FRAME_SYNC_CONFIG_1_OFS: frame_sync_config_1_reg <= pwdata[3:0];
        ocr_pkg::GPIO_CTRL_OFS: begin
          gpio_dir_reg <= pwdata[2:0];
          gpio_out_reg <= pwdata[ocr_pkg::GPIO_OUT_POS +: 3];
        end
        default: begin
        end
      endcase
    end
  end

  // Phase accumulators, one per output clock
  genvar g;
  generate
    for (g = 0; g < ocr_pkg::NUM_CLK; g++) begin : gen_nco
      logic [32:0] sum;
      assign sum = {1'b0, acc_reg[g]} + {1'b0, freq_reg[g]};
      assign acc_next[g] = (sum >= {1'b0, PHASE_MOD_KHZ}) ? 32'(sum - {1'b0, PHASE_MOD_KHZ}) : sum[31:0];
      assign clk_next[g] = acc_next[g] >= HALF_MOD;
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          acc_reg[g] <= 32'h0000_0000;
          clk_reg[g] <= 1'b0;
        end else begin
          acc_reg[g] <= acc_next[g];
          clk_reg[g] <= clk_next[g];
        end
      end
    end
  endgenerate

  // Differential pairs from clock sources 4 to 7
  generate
    for (g = 0; g < 4; g++) begin : gen_diff
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          diff_reg[g] <= 2'b01;
        end else begin
          diff_reg[g].true_lvl <= clk_next[g + 3];
          diff_reg[g].comp_lvl <= ~clk_next[g + 3];
        end
      end
    end
  endgenerate

  // Copy enables switch only while the source is low
  generate
    for (g = 0; g < 5; g++) begin : gen_copy_en
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          copy_en_reg[g] <= 1'b0;
        end else if (!clk_next[g]) begin
          copy_en_reg[g] <= output_config_6_reg[g];
        end
      end
    end
  endgenerate

  // Shared pins: clock copy or general I/O
  generate
    for (g = 0; g < 3; g++) begin : gen_shared
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          copy_pin_out_reg[g] <= 1'b0;
          copy_pin_oe_n_reg[g] <= 1'b1;
        end else if (copy_en_reg[g]) begin
          copy_pin_out_reg[g] <= clk_next[g];
          copy_pin_oe_n_reg[g] <= 1'b0;
        end else begin
          copy_pin_out_reg[g] <= gpio_out_reg[g];
          copy_pin_oe_n_reg[g] <= ~gpio_dir_reg[g];
        end
      end
    end
  endgenerate

  // Dedicated copy pins, static low and released when off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      copy4_reg <= 1'b0;
      copy4_oe_n_reg <= 1'b1;
      copy5_reg <= 1'b0;
      copy5_oe_n_reg <= 1'b1;
    end else begin
      copy4_reg <= copy_en_reg[3] & clk_next[3];
      copy4_oe_n_reg <= ~(copy_en_reg[3] | output_config_6_reg[3]);
      copy5_reg <= copy_en_reg[4] & clk_next[4];
      copy5_oe_n_reg <= ~(copy_en_reg[4] | output_config_6_reg[4]);
    end
  end

  // Frame counters, multiframe aligned to every fourth frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_cnt_reg <= 16'h0000;
      slow_idx_reg <= 2'h0;
    end else if (fast_cnt_reg == FAST_LAST) begin
      fast_cnt_reg <= 16'h0000;
      slow_idx_reg <= (slow_idx_reg == SLOW_LAST) ? 2'h0 : slow_idx_reg + 2'h1;
    end else begin
      fast_cnt_reg <= fast_cnt_reg + 16'h0001;
    end
  end

  // Sync outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_sync_reg <= 1'b0;
      multiframe_sync_reg <= 1'b0;
    end else begin
      frame_sync_reg <= sync_level(fast_cnt_reg < FAST_HALF, fast_cnt_reg < PULSE_CYC,
                                   frame_sync_config_1_reg.fast);
      multiframe_sync_reg <= sync_level(slow_idx_reg < SLOW_HALF,
                                        slow_idx_reg == 2'h0 && fast_cnt_reg < PULSE_CYC,
                                        frame_sync_config_1_reg.slow);
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign output_clock_1 = clk_reg[0];
  assign output_clock_2 = clk_reg[1];
  assign output_clock_3 = clk_reg[2];
  assign output_clock_4 = clk_reg[3];
  assign output_clock_5 = clk_reg[4];
  assign diff_out4_true = diff_reg[0].true_lvl;
  assign diff_out4_comp = diff_reg[0].comp_lvl;
  assign diff_out5_true = diff_reg[1].true_lvl;
  assign diff_out5_comp = diff_reg[1].comp_lvl;
  assign diff_out6_true = diff_reg[2].true_lvl;
  assign diff_out6_comp = diff_reg[2].comp_lvl;
  assign diff_out7_true = diff_reg[3].true_lvl;
  assign diff_out7_comp = diff_reg[3].comp_lvl;
  assign out4_signal_format = master_config_8_reg[ocr_pkg::MC8_OUT4_POS +: 2];
  assign out5_signal_format = master_config_8_reg[ocr_pkg::MC8_OUT5_POS +: 2];
  assign out6_signal_format = master_config_8_reg[ocr_pkg::MC8_OUT6_POS +: 2];
  assign out7_signal_format = master_config_8_reg[ocr_pkg::MC8_OUT7_POS +: 2];
  assign copy_pin_out = copy_pin_out_reg;
  assign copy_pin_oe_n = copy_pin_oe_n_reg;
  assign copy4_pin = copy4_reg;
  assign copy4_pin_oe_n = copy4_oe_n_reg;
  assign copy5_pin = copy5_reg;
  assign copy5_pin_oe_n = copy5_oe_n_reg;
  assign frame_sync_out = frame_sync_reg;
  assign multiframe_sync_out = multiframe_sync_reg;

endmodule

// File: ocr_output_routing_asserts.sv
`timescale 1ns/10ps
module ocr_output_routing_asserts #(
  parameter int FAST_FRAME_CYCLES = 6250
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic output_clock_4,
  input wire logic output_clock_5,
  input wire logic diff_out4_true,
  input wire logic diff_out4_comp,
  input wire logic diff_out5_true,
  input wire logic diff_out5_comp,
  input wire logic copy4_pin,
  input wire logic copy4_pin_oe_n,
  input wire logic copy5_pin,
  input wire logic copy5_pin_oe_n,
  input wire logic frame_sync_out,
  input wire logic multiframe_sync_out
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [15:0] fast_run;
  logic [15:0] slow_run;
  logic fast_prev;
  logic slow_prev;
  // Cycles since the last sync edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_prev <= 1'h0;
      fast_run <= 16'h0000;
    end else begin
      fast_prev <= frame_sync_out;
      fast_run <= (frame_sync_out != fast_prev) ? 16'h0000 : fast_run + 16'h0001;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slow_prev <= 1'h0;
      slow_run <= 16'h0000;
    end else begin
      slow_prev <= multiframe_sync_out;
      slow_run <= (multiframe_sync_out != slow_prev) ? 16'h0000 : slow_run + 16'h0001;
    end
  end
  a_pair4_mirror: assert property (diff_out4_true == output_clock_4)
    else $error("pair 4 differs from clock 4");
  a_pair5_mirror: assert property (diff_out5_true == output_clock_5)
    else $error("pair 5 differs from clock 5");
  a_pair_comp: assert property (diff_out4_comp != diff_out4_true && diff_out5_comp != diff_out5_true)
    else $error("pair legs not complementary");
  a_ready_time: assert property (psel && penable && !pready |=> pready)
    else $error("no ready after access");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than a cycle");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_copy4_off: assert property (copy4_pin_oe_n |-> !copy4_pin)
    else $error("copy 4 toggles while off");
  a_copy5_off: assert property (copy5_pin_oe_n |-> !copy5_pin)
    else $error("copy 5 toggles while off");
  a_fast_run: assert property (fast_run < 2 * FAST_FRAME_CYCLES)
    else $error("frame sync stuck");
  a_slow_run: assert property (slow_run < 8 * FAST_FRAME_CYCLES)
    else $error("multiframe sync stuck");
endmodule
bind ocr_output_routing ocr_output_routing_asserts #(.FAST_FRAME_CYCLES(FAST_FRAME_CYCLES))
  ocr_output_routing_asserts_inst (.*);

// File: ocr_line_card_model.sv
`timescale 1ns/10ps
module ocr_line_card_model (
  input wire logic pclk,
  input wire logic [2:0] copy_pin_out,
  input wire logic [2:0] copy_pin_oe_n,
  output logic [2:0] copy_pin_in
);
  logic [2:0] ext_reg = 3'h0;
  // Far side drives a changing pattern when the pin is released
  always_ff @(posedge pclk) begin
    ext_reg <= ext_reg + 3'h1;
  end
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      copy_pin_in[i] = copy_pin_oe_n[i] ? ext_reg[i] : copy_pin_out[i];
    end
  end
endmodule

// File: testbench.sv
`timescale 1ns/10ps
`define check(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end
module testbench;
  localparam int FFC = 40;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, output_clock_1, output_clock_2, output_clock_3, output_clock_4, output_clock_5;
  logic diff_out4_true, diff_out4_comp, diff_out5_true, diff_out5_comp, diff_out6_true, diff_out6_comp;
  logic diff_out7_true, diff_out7_comp, copy4_pin, copy4_pin_oe_n, copy5_pin, copy5_pin_oe_n;
  logic frame_sync_out, multiframe_sync_out;
  logic [1:0] out4_signal_format, out5_signal_format, out6_signal_format, out7_signal_format;
  logic [2:0] copy_pin_out, copy_pin_oe_n, copy_pin_in;
  logic [31:0] rd;
  logic er;
  logic c0;
  int n_mismatch = 0;
  int tests_run = 0;
  int f, s, ef, es;
  logic [31:0] rst_tab [7] = '{ocr_pkg::FREQ1_RST, ocr_pkg::FREQ2_RST, ocr_pkg::FREQ3_RST,
    ocr_pkg::FREQ4_RST, ocr_pkg::FREQ5_RST, ocr_pkg::FREQ6_RST, ocr_pkg::FREQ7_RST};
  always #10 pclk = ~pclk;
  ocr_output_routing #(.FAST_FRAME_CYCLES(FFC)) ocr_output_routing_inst (.*);
  ocr_line_card_model ocr_line_card_model_inst (.*);
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) begin
      @(posedge pclk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    // Pins follow their registers one cycle later
    repeat (2) @(negedge pclk);
  endtask
  task automatic count_high;
    f = 0;
    s = 0;
    repeat (4 * FFC) begin
      @(negedge pclk);
      f += (frame_sync_out === 1'h1);
      s += (multiframe_sync_out === 1'h1);
    end
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'h1;
    @(negedge pclk);
    `check("fmt6", ocr_pkg::FMT_LVDS, out6_signal_format)
    `check("fmt7", ocr_pkg::FMT_LVDS, out7_signal_format)
    `check("copy4 oe", 1'h1, copy4_pin_oe_n)
    `check("copy5 oe", 1'h1, copy5_pin_oe_n)
    for (int i = 0; i < 7; i++) begin
      apb(1'h0, 8'(4 * i), 32'h0000_0000);
      `check("freq", rst_tab[i], rd)
    end
    $display("reset test done");
    apb(1'h1, ocr_pkg::MASTER_CONFIG_8_OFS, 32'h0000_00e4);
    `check("fmt", 8'he4, {out7_signal_format, out6_signal_format, out5_signal_format,
      out4_signal_format})
    apb(1'h0, 8'h30, 32'h0000_0000);
    `check("unmapped err", 1'h1, er)
    `check("unmapped data", 32'h0000_0000, rd)
    apb(1'h1, 8'h00, 32'h0004_c4b4);
    c0 = output_clock_1;
    @(negedge pclk);
    `check("clock1 toggle", ~c0, output_clock_1)
    $display("format test done");
    apb(1'h1, ocr_pkg::GPIO_CTRL_OFS, 32'h0000_0057);
    `check("gpio oe", 3'h0, copy_pin_oe_n)
    `check("gpio out", 3'h5, copy_pin_out)
    apb(1'h0, ocr_pkg::STATUS_OFS, 32'h0000_0000);
    `check("gpio in", 3'h5, rd[2:0])
    apb(1'h1, ocr_pkg::OUTPUT_CONFIG_6_OFS, 32'h0000_001f);
    `check("copy4 drive", 1'h0, copy4_pin_oe_n)
    repeat (50) @(negedge pclk);
    apb(1'h0, ocr_pkg::STATUS_OFS, 32'h0000_0000);
    `check("copy on", 5'h1f, rd[20:16])
    repeat (8) begin
      c0 = diff_out7_true;
      @(negedge pclk);
      `check("pair7 toggle", ~c0, diff_out7_true)
      `check("pair7 legs", ~diff_out7_true, diff_out7_comp)
      `check("pair6 legs", ~diff_out6_true, diff_out6_comp)
      `check("copy123", {output_clock_3, output_clock_2, output_clock_1}, copy_pin_out)
      `check("copy45", {output_clock_5, output_clock_4}, {copy5_pin, copy4_pin})
    end
    apb(1'h1, ocr_pkg::OUTPUT_CONFIG_6_OFS, 32'h0000_0000);
    repeat (50) @(negedge pclk);
    `check("copy off", 3'h4, {copy4_pin_oe_n, copy4_pin, copy5_pin})
    `check("gpio back", 3'h5, copy_pin_out)
    $display("copy test done");
    for (int m = 0; m < 16; m++) begin
      apb(1'h1, ocr_pkg::FRAME_SYNC_CONFIG_1_OFS, 32'(m));
      repeat (5 * FFC) @(negedge pclk);
      count_high();
      ef = 4 * (m[1] ? ocr_pkg::SYNC_PULSE_CYCLES : FFC / 2);
      es = m[3] ? ocr_pkg::SYNC_PULSE_CYCLES : 2 * FFC;
      if (m[0]) ef = 4 * FFC - ef;
      if (m[2]) es = 4 * FFC - es;
      `check("fast high", ef, f)
      `check("slow high", es, s)
    end
    $display("sync test done");
    conclude();
  end
  initial begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    conclude();
  end
endmodule
